// ===== scss_pkg.sv
// constants and types for the system clock source selector
`default_nettype none
package scss_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int STARTUP_NS = 10000;
    localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TUNE_SETTLE_NS = 1000000;
    localparam int TUNE_SETTLE_CYC = TUNE_SETTLE_NS / CLK_PERIOD_NS;
    localparam int TUNE_STEPS = 32;
    // ----------------------------------------------------------------
    // register map (printed offsets are word indices)
    // ----------------------------------------------------------------
    localparam logic [11:0] CTRL_IDX = 12'h08F;
    localparam logic [11:0] TUNE_IDX = 12'h090;
    localparam logic [11:0] CTRL_ADDR = 12'(CTRL_IDX << 2);
    localparam logic [11:0] TUNE_ADDR = 12'(TUNE_IDX << 2);
    localparam int SCS_BIT = 0;
    localparam int LTS_BIT = 1;
    localparam int HTS_BIT = 2;
    localparam int START_TIMER_DONE_FLAG_BIT = 3;
    localparam int FSEL_LSB = 4;
    localparam logic [2:0] FSEL_RESET = 3'h6;
    localparam logic [2:0] FSEL_LF = 3'h0;
    localparam logic [4:0] TUNE_RESET = 5'h00;
    // ----------------------------------------------------------------
    // oscillator models: 16-bit phase accumulators on pclk
    // ----------------------------------------------------------------
    localparam logic [15:0] HF_INC_BASE = 16'h28F6;
    localparam logic [15:0] HF_INC_STEP = 16'h004F;
    localparam logic [15:0] LF_INC = 16'h0029;
    // ----------------------------------------------------------------
    // configuration-word oscillator field codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CFG_LP = 3'h0;
    localparam logic [2:0] CFG_XT = 3'h1;
    localparam logic [2:0] CFG_HS = 3'h2;
    localparam logic [2:0] CFG_EC = 3'h3;
    localparam logic [2:0] CFG_INTIO = 3'h4;
    localparam logic [2:0] CFG_INTCK = 3'h5;
    localparam logic [2:0] CFG_RC_WITH_IO_MODE = 3'h6;
    localparam logic [2:0] CFG_RC = 3'h7;
    typedef enum logic [1:0] {SW_IDLE, SW_START, SW_FALL, SW_RISE} scss_sw_state_type;
    typedef struct packed {
        logic out;
        logic oe;
    } scss_pin_type;
endpackage
`default_nettype wire

// ===== scss_top.sv
// system clock source selector with apb registers and oscillator pins
`default_nettype none
// Operation
// R1 - RC mode: clock/4 on output pin
// R2 - RC-with-IO: output pin is port A bit 4
// R3 - internal clockout: input pin IO, clock/4 out
// R4 - internal IO: both pins general IO
// R5 - HF runs: (select or two-speed), field nonzero
// R6 - HF stable flag at control bit 2
// R7 - tuning: 5-bit signed, reset zero
// R8 - tuning slews, settles within 1 ms
// R9 - tuning never affects LF oscillator
// R10 - LF runs for field 000 or users
// R11 - LF stable flag at control bit 1
// R12 - field bits 6:4 pick eight frequencies
// R13 - reset loads field with 110
// R14 - 10 us start-up if target off
// R15 - switch: falling, hold low, rising, connect
// R16 - HF-derived changes need no start-up
// R17 - select bit: config field or internal
// R18 - reset clears select bit
// R19 - automatic switches keep select bit
// R20 - start-timer flag only after crystal timeout
// R21 - postscaler divides HF by powers of two
module scss_top #(
    parameter int TUNE_SETTLE_CYC = scss_pkg::TUNE_SETTLE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration and oscillator users
    input wire logic [2:0] config_osc_field,
    input wire logic two_speed_enable,
    input wire logic power_up_timer_en,
    input wire logic watchdog_timer_en,
    input wire logic clock_fail_monitor_en,
    input wire logic lcd_lf_select,
    input wire logic osc_start_timer_done,
    // oscillator pins
    input wire logic osc_input_pin_in,
    output var scss_pkg::scss_pin_type osc_input_pin_drive,
    input wire logic osc_output_clock_out_pin_in,
    output var scss_pkg::scss_pin_type osc_output_clock_out_pin_drive,
    // general io sharing the pins
    input wire scss_pkg::scss_pin_type gpio_input_pin_drive,
    input wire scss_pkg::scss_pin_type port_a_bit_four_drive,
    output logic gpio_input_pin_level,
    output logic port_a_bit_four_level,
    // system clock
    output logic sys_clk,
    output logic sys_clk_internal
);
    localparam int TUNE_STEP_CYC = TUNE_SETTLE_CYC / scss_pkg::TUNE_STEPS;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    function automatic logic sel_level(input logic [2:0] s, input logic hf,
                                       input logic [5:0] ps, input logic lf);
        unique case (s)
            3'h7: sel_level = hf;
            3'h6: sel_level = ps[0];
            3'h5: sel_level = ps[1];
            3'h4: sel_level = ps[2];
            3'h3: sel_level = ps[3];
            3'h2: sel_level = ps[4];
            3'h1: sel_level = ps[5];
            3'h0: sel_level = lf;
        endcase
    endfunction

    function automatic logic cfg_internal(input logic [2:0] c);
        cfg_internal = (c == scss_pkg::CFG_INTIO) || (c == scss_pkg::CFG_INTCK);
    endfunction

    function automatic logic cfg_crystal(input logic [2:0] c);
        cfg_crystal = (c == scss_pkg::CFG_LP) || (c == scss_pkg::CFG_XT) ||
                      (c == scss_pkg::CFG_HS);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pin_s1_reg;
    logic [1:0] pin_s2_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 2'h0;
            pin_s2_reg <= 2'h0;
        end else begin
            pin_s1_reg <= {osc_output_clock_out_pin_in, osc_input_pin_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // registers and apb slave
    // ----------------------------------------------------------------
    logic system_clock_select_bit_reg;
    logic [2:0] frequency_select_field_reg;
    logic [4:0] tuning_value_reg;
    logic high_freq_stable_flag_reg;
    logic low_freq_stable_flag_reg;
    logic start_timer_done_flag_reg;
    logic apb_wr;
    logic [31:0] rd_next;
    logic hit;

    assign apb_wr = psel && penable && pready && pwrite;

    always_comb begin
        hit = 1'b1;
        rd_next = 32'h0000_0000;
        if (paddr == scss_pkg::CTRL_ADDR) begin
            rd_next[scss_pkg::FSEL_LSB +: 3] = frequency_select_field_reg;
            rd_next[scss_pkg::START_TIMER_DONE_FLAG_BIT] = start_timer_done_flag_reg;
            rd_next[scss_pkg::HTS_BIT] = high_freq_stable_flag_reg;
            rd_next[scss_pkg::LTS_BIT] = low_freq_stable_flag_reg;
            rd_next[scss_pkg::SCS_BIT] = system_clock_select_bit_reg;
        end else if (paddr == scss_pkg::TUNE_ADDR) begin
            rd_next[4:0] = tuning_value_reg;
        end else begin
            hit = 1'b0;
        end
    end

    // no wait state: answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // R13 R18 reset values of control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_select_bit_reg <= 1'b0;
            frequency_select_field_reg <= scss_pkg::FSEL_RESET;
        end else if (apb_wr && hit && paddr == scss_pkg::CTRL_ADDR) begin
            // R19 only software moves the select bit
            system_clock_select_bit_reg <= pwdata[scss_pkg::SCS_BIT];
            // R12 field at bits 6:4
            frequency_select_field_reg <= pwdata[scss_pkg::FSEL_LSB +: 3];
        end
    end

    // R7 tuning register, five signed bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tuning_value_reg <= scss_pkg::TUNE_RESET;
        end else if (apb_wr && hit && paddr == scss_pkg::TUNE_ADDR) begin
            tuning_value_reg <= pwdata[4:0];
        end
    end

    // ----------------------------------------------------------------
    // tuning slew
    // ----------------------------------------------------------------
    logic [4:0] trim_reg;
    logic [15:0] step_cnt_reg;

    // R8 one trim step per interval, full range within 1 ms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_reg <= scss_pkg::TUNE_RESET;
            step_cnt_reg <= 16'h0000;
        end else if (step_cnt_reg == 16'(TUNE_STEP_CYC - 1)) begin
            step_cnt_reg <= 16'h0000;
            if ($signed(trim_reg) < $signed(tuning_value_reg)) begin
                trim_reg <= trim_reg + 5'h01;
            end else if ($signed(trim_reg) > $signed(tuning_value_reg)) begin
                trim_reg <= trim_reg - 5'h01;
            end
        end else begin
            step_cnt_reg <= step_cnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // oscillators: index 0 low frequency, index 1 high frequency
    // ----------------------------------------------------------------
    scss_pkg::scss_sw_state_type sw_state_reg;
    logic [2:0] act_sel_reg;
    logic [2:0] new_sel_reg;
    logic [1:0] osc_run;
    logic [15:0] osc_inc [2];
    logic [15:0] acc_reg [2];
    logic [9:0] su_cnt_reg [2];
    logic rdy_reg [2];
    logic busy;

    assign busy = sw_state_reg != scss_pkg::SW_IDLE;

    // R5 high-frequency run condition, kept alive during a switch while still connected
    assign osc_run[1] = ((system_clock_select_bit_reg || two_speed_enable) &&
                         frequency_select_field_reg != scss_pkg::FSEL_LF) ||
                        (busy && act_sel_reg != scss_pkg::FSEL_LF);
    // R10 low-frequency run condition
    assign osc_run[0] = ((system_clock_select_bit_reg || two_speed_enable) &&
                         frequency_select_field_reg == scss_pkg::FSEL_LF) ||
                        power_up_timer_en || watchdog_timer_en ||
                        clock_fail_monitor_en || lcd_lf_select ||
                        (busy && act_sel_reg == scss_pkg::FSEL_LF);
    assign osc_inc[1] = scss_pkg::HF_INC_BASE +
                        {{11{trim_reg[4]}}, trim_reg} * scss_pkg::HF_INC_STEP;
    // R9 low-frequency step ignores tuning
    assign osc_inc[0] = scss_pkg::LF_INC;

    for (genvar gi = 0; gi < 2; gi++) begin : g_osc
        // R14 start-up delay after an oscillator is switched on
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                acc_reg[gi] <= 16'h0000;
                su_cnt_reg[gi] <= 10'h000;
                rdy_reg[gi] <= 1'b0;
            end else if (!osc_run[gi]) begin
                acc_reg[gi] <= 16'h0000;
                su_cnt_reg[gi] <= 10'h000;
                rdy_reg[gi] <= 1'b0;
            end else begin
                acc_reg[gi] <= acc_reg[gi] + osc_inc[gi];
                if (su_cnt_reg[gi] == 10'(scss_pkg::STARTUP_CYC - 1)) begin
                    rdy_reg[gi] <= 1'b1;
                end else begin
                    su_cnt_reg[gi] <= su_cnt_reg[gi] + 10'h001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // postscaler
    // ----------------------------------------------------------------
    logic hf_q_reg;
    logic [5:0] ps_reg;
    logic hf_lvl;
    logic lf_lvl;

    assign hf_lvl = acc_reg[1][15];
    assign lf_lvl = acc_reg[0][15];

    // R21 ripple of halvings below 8 MHz
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_q_reg <= 1'b0;
            ps_reg <= 6'h00;
        end else begin
            hf_q_reg <= hf_lvl;
            if (hf_lvl && !hf_q_reg) begin
                ps_reg <= ps_reg + 6'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // glitch-free frequency switch
    // ----------------------------------------------------------------
    logic cur_lvl;
    logic new_lvl;
    logic cur_q_reg;
    logic new_q_reg;
    logic hold_reg;
    logic tgt_rdy;
    logic int_clk;

    assign cur_lvl = sel_level(act_sel_reg, hf_lvl, ps_reg, lf_lvl);
    assign new_lvl = sel_level(new_sel_reg, hf_lvl, ps_reg, lf_lvl);
    assign tgt_rdy = (new_sel_reg == scss_pkg::FSEL_LF) ? rdy_reg[0] : rdy_reg[1];
    assign int_clk = cur_lvl && !hold_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q_reg <= 1'b0;
            new_q_reg <= 1'b0;
        end else begin
            cur_q_reg <= cur_lvl;
            new_q_reg <= new_lvl;
        end
    end

    // R15 fall of old clock, hold low, rise of new clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_state_reg <= scss_pkg::SW_IDLE;
            act_sel_reg <= scss_pkg::FSEL_RESET;
            new_sel_reg <= scss_pkg::FSEL_RESET;
            hold_reg <= 1'b0;
        end else begin
            unique case (sw_state_reg)
                scss_pkg::SW_IDLE: begin
                    if (frequency_select_field_reg != act_sel_reg) begin
                        new_sel_reg <= frequency_select_field_reg;
                        sw_state_reg <= scss_pkg::SW_START;
                    end
                end
                // R14 R16 waits only while the target has not finished start-up
                scss_pkg::SW_START: begin
                    if (tgt_rdy) begin
                        sw_state_reg <= scss_pkg::SW_FALL;
                    end
                end
                scss_pkg::SW_FALL: begin
                    if (cur_q_reg && !cur_lvl) begin
                        hold_reg <= 1'b1;
                        sw_state_reg <= scss_pkg::SW_RISE;
                    end
                end
                scss_pkg::SW_RISE: begin
                    if (new_lvl && !new_q_reg) begin
                        act_sel_reg <= new_sel_reg;
                        hold_reg <= 1'b0;
                        sw_state_reg <= scss_pkg::SW_IDLE;
                    end
                end
            endcase
        end
    end

    // R6 R11 stable flags follow the oscillators outside a switch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_freq_stable_flag_reg <= 1'b0;
            low_freq_stable_flag_reg <= 1'b0;
        end else if (!busy) begin
            high_freq_stable_flag_reg <= rdy_reg[1];
            low_freq_stable_flag_reg <= rdy_reg[0];
        end
    end

    // ----------------------------------------------------------------
    // source select and clock out
    // ----------------------------------------------------------------
    logic use_int;
    logic src_lvl;
    logic src_q_reg;
    logic [1:0] div_reg;

    // R20 flag only from a crystal-mode start-up timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_timer_done_flag_reg <= 1'b0;
        end else begin
            start_timer_done_flag_reg <= cfg_crystal(config_osc_field) &&
                                         osc_start_timer_done;
        end
    end

    // R17 select bit picks internal, otherwise the config field decides
    assign use_int = system_clock_select_bit_reg || cfg_internal(config_osc_field) ||
                     (cfg_crystal(config_osc_field) && !start_timer_done_flag_reg);
    assign src_lvl = use_int ? int_clk : pin_s2_reg[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q_reg <= 1'b0;
            div_reg <= 2'h0;
            sys_clk <= 1'b0;
            sys_clk_internal <= 1'b0;
        end else begin
            src_q_reg <= src_lvl;
            sys_clk <= src_lvl;
            sys_clk_internal <= use_int;
            if (src_lvl && !src_q_reg) begin
                div_reg <= div_reg + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_input_pin_drive <= '0;
            osc_output_clock_out_pin_drive <= '0;
            gpio_input_pin_level <= 1'b0;
            port_a_bit_four_level <= 1'b0;
        end else begin
            gpio_input_pin_level <= pin_s2_reg[0];
            port_a_bit_four_level <= pin_s2_reg[1];
            // R3 R4 input pin released to io in internal modes
            osc_input_pin_drive <= cfg_internal(config_osc_field) ?
                                   gpio_input_pin_drive : '0;
            unique case (config_osc_field)
                // R1 R3 divide-by-4 clock out, low while the switch holds
                scss_pkg::CFG_RC, scss_pkg::CFG_INTCK: begin
                    osc_output_clock_out_pin_drive.out <= div_reg[1] && !hold_reg;
                    osc_output_clock_out_pin_drive.oe <= 1'b1;
                end
                // R2 R4 output pin serves as port A bit 4
                scss_pkg::CFG_RC_WITH_IO_MODE, scss_pkg::CFG_INTIO: begin
                    osc_output_clock_out_pin_drive <= port_a_bit_four_drive;
                end
                default: begin
                    osc_output_clock_out_pin_drive <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    localparam int SU_WAIT = 504;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // pin drives still hold reset values one edge after release
    chk_rc_clock_out: assert property ( // R1
        presetn && config_osc_field == scss_pkg::CFG_RC |=>
            osc_output_clock_out_pin_drive.oe &&
            osc_output_clock_out_pin_drive.out == ($past(div_reg[1]) && !$past(hold_reg)))
        else $error("rc mode clock out wrong");
    chk_rc_with_io_mode_port: assert property ( // R2
        presetn && config_osc_field == scss_pkg::CFG_RC_WITH_IO_MODE |=>
            osc_output_clock_out_pin_drive == $past(port_a_bit_four_drive))
        else $error("rc_with_io_mode pin not port a bit 4");
    chk_intio_release: assert property ( // R4
        presetn && config_osc_field == scss_pkg::CFG_INTIO |=>
            osc_input_pin_drive == $past(gpio_input_pin_drive))
        else $error("input pin not released to io");
    chk_hf_startup: assert property ( // R5
        $rose(osc_run[1]) ##1 osc_run[1] [*2] |-> ##[1:SU_WAIT] rdy_reg[1])
        else $error("hf oscillator failed to start");
    chk_hts_flag: assert property ( // R6
        high_freq_stable_flag_reg |-> $past(rdy_reg[1]) || busy)
        else $error("hf stable flag without stable osc");
    chk_trim_step: assert property ( // R8
        $changed(trim_reg) |-> $past(step_cnt_reg) == 16'(TUNE_STEP_CYC - 1))
        else $error("trim moved off its interval");
    chk_lf_untuned: assert property ( // R9
        osc_run[0] && $past(osc_run[0]) |-> acc_reg[0] == $past(acc_reg[0]) + scss_pkg::LF_INC)
        else $error("lf step not fixed");
    chk_switch_hold: assert property ( // R15
        hold_reg ##1 config_osc_field == scss_pkg::CFG_INTCK |-> !osc_output_clock_out_pin_drive.out)
        else $error("clock out not held low in switch");
    chk_connect_ready: assert property ( // R14
        $changed(act_sel_reg) |-> $past(tgt_rdy) && $past(sw_state_reg) == scss_pkg::SW_RISE)
        else $error("connected before target ready");
    chk_select_internal: assert property ( // R17
        system_clock_select_bit_reg |=> sys_clk_internal)
        else $error("select bit ignored");
    chk_timer_flag: assert property ( // R20
        start_timer_done_flag_reg |-> $past(cfg_crystal(config_osc_field)))
        else $error("start timer flag outside crystal mode");

    cov_switch_done: cover property (sw_state_reg == scss_pkg::SW_RISE ##1 !busy);
    cov_lf_connect: cover property ($changed(act_sel_reg) && act_sel_reg == scss_pkg::FSEL_LF);
    cov_tune_move: cover property ($changed(trim_reg));
    cov_rc_clock: cover property ($rose(osc_output_clock_out_pin_drive.out));
endmodule
`default_nettype wire

// ===== scss_rc_net.sv
// external rc network and clock-out user
`default_nettype none
module scss_rc_net #(
    parameter int HALF_NS = 160
) (
    // rc network
    input wire logic rc_on,
    output logic rc_clk,
    // clock-out user
    input wire logic clk_out,
    output int rises
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rc_clk = 1'b0;
    always #(HALF_NS) rc_clk = rc_on ? ~rc_clk : 1'b0;
    initial rises = 0;
    always @(posedge clk_out) rises = rises + 1;
endmodule
`default_nettype wire

// ===== test_system_clock_source_select.sv
// self-checking bench for the system clock source selector
`default_nettype none
module test_system_clock_source_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sys_int, rc_clk, in_wire, out_wire, gpio_lvl, pa4_lvl, sclk;
    logic osc_start_timer = 1'b0;
    logic [2:0] cfg = 3'h7;
    scss_pkg::scss_pin_type in_drv, out_drv;
    scss_pkg::scss_pin_type gpio_req = 2'h3;
    scss_pkg::scss_pin_type pa4_req = 2'h2;
    int failures = 0;
    int samples_checked = 0;
    int rises;
    always #10 pclk = ~pclk;
    assign in_wire = in_drv.oe ? in_drv.out : rc_clk;
    assign out_wire = out_drv.oe ? out_drv.out : 1'b1;
    scss_top #(.TUNE_SETTLE_CYC(320)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .config_osc_field(cfg), .two_speed_enable(1'b0), .power_up_timer_en(pwr),
        .watchdog_timer_en(1'b0), .clock_fail_monitor_en(1'b0), .lcd_lf_select(1'b0),
        .osc_start_timer_done(osc_start_timer), .osc_input_pin_in(in_wire), .osc_input_pin_drive(in_drv),
        .osc_output_clock_out_pin_in(out_wire), .osc_output_clock_out_pin_drive(out_drv),
        .gpio_input_pin_drive(gpio_req), .port_a_bit_four_drive(pa4_req),
        .gpio_input_pin_level(gpio_lvl), .port_a_bit_four_level(pa4_lvl), .sys_clk(sclk),
        .sys_clk_internal(sys_int));
    scss_rc_net u_rc (.rc_on(cfg[2] & cfg[1]), .rc_clk(rc_clk), .clk_out(out_wire),
        .rises(rises));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) failures++;
    endtask
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(what, exp, q);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("reset outputs", 32'h0, {29'h0, sclk, sys_int, pready});
        presetn <= 1'b1;
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        rd("control", scss_pkg::CTRL_ADDR, 32'h60);
        wr(scss_pkg::CTRL_ADDR, 32'h6E);
        rd("control ro", scss_pkg::CTRL_ADDR, 32'h60);
        rd("tuning", scss_pkg::TUNE_ADDR, 32'h0);
        wr(scss_pkg::TUNE_ADDR, 32'h0F);
        rd("tuning max", scss_pkg::TUNE_ADDR, 32'h0F);
        wr(scss_pkg::TUNE_ADDR, 32'hFFFFFFF0);
        rd("tuning min", scss_pkg::TUNE_ADDR, 32'h10);
        wr(scss_pkg::TUNE_ADDR, 32'h0);
        apb(1'b1, 12'h004, 32'hFF, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
    endtask
    task automatic t_pins;
        for (int m = 4; m < 8; m++) begin
            @(posedge pclk);
            cfg <= 3'(m);
            repeat (4) @(posedge pclk);
            @(negedge pclk);
            chk("input pin oe", {31'h0, m < 6}, {31'h0, in_drv.oe});
            chk("output pin oe", {31'h0, m[0]}, {31'h0, out_drv.oe});
            if (m < 6) chk("gpio level", 32'h1, {31'h0, gpio_lvl});
            if (m % 2 == 0) chk("port a level", 32'h1, {31'h0, pa4_lvl});
        end
    endtask
    task automatic t_div(input logic [2:0] mode, input int cyc, input int lo, input int hi);
        int r0;
        @(posedge pclk);
        cfg <= mode;
        repeat (60) @(posedge pclk);
        r0 = rises;
        repeat (cyc) @(posedge pclk);
        chk("clock out edges", 32'h1, {31'h0, (rises - r0) inside {[lo:hi]}});
    endtask
    task automatic t_switch;
        @(posedge pclk);
        cfg <= scss_pkg::CFG_INTCK;
        wr(scss_pkg::CTRL_ADDR, 32'h01);
        repeat (2500) @(posedge pclk);
        rd("control lf", scss_pkg::CTRL_ADDR, 32'h03);
        chk("internal source", 32'h1, {31'h0, sys_int});
        wr(scss_pkg::CTRL_ADDR, 32'h71);
        repeat (2500) @(posedge pclk);
        rd("control hf", scss_pkg::CTRL_ADDR, 32'h75);
        t_div(scss_pkg::CFG_INTCK, 500, 19, 21);
        wr(scss_pkg::CTRL_ADDR, 32'h51);
        t_div(scss_pkg::CFG_INTCK, 500, 4, 6);
        pwr <= 1'b1;
        repeat (2500) @(posedge pclk);
        rd("control users", scss_pkg::CTRL_ADDR, 32'h57);
        cfg <= scss_pkg::CFG_XT;
        osc_start_timer <= 1'b1;
        rd("control timer", scss_pkg::CTRL_ADDR, 32'h5F);
        osc_start_timer <= 1'b0;
        pwr <= 1'b0;
        cfg <= scss_pkg::CFG_RC;
        do_reset();
        rd("control again", scss_pkg::CTRL_ADDR, 32'h60);
    endtask
    task automatic report_and_stop;
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end
    initial begin
        do_reset();
        t_regs();
        t_pins();
        t_div(scss_pkg::CFG_RC, 1024, 15, 17);
        t_switch();
        report_and_stop();
    end
endmodule
`default_nettype wire
